//--- coproc_and_loop_exec_tb.sv
// Self-checking testbench of the coprocessor and loop execution block
`timescale 1ns/100ps
module coproc_and_loop_exec_tb;
    logic clk = 0, resetn = 0, instrValid = 0, extValid = 0, cpReqValid, cpReqIsCond;
    logic instrReady, extReady, ccLoad, cpRespValid, cpRespCondTrue, cpRespCcWrite;
    logic regWr, byteWr, pcLoad, trapTake, lineFTrap, mmuReq, illegalEa, done, lastCond;
    logic [2:0] cpReqId, dnIndex, byteEaMode, byteEaReg, lastId, id, m, r, f;
    logic [3:0] dly = 0, c;
    logic [4:0] ccIn = 0, ccValue, cpRespCc, gCc;
    logic [7:0] byteData, trapVector, gEv, gByte, eB;
    logic [15:0] instrWord = 0, extWord = 0, cpReqWord, lastWord, cw;
    logic [31:0] instrAddr = 0, dnRead = 0, regData, pcValue, trapPc, gPc, gReg, a, eR, eP;
    int nReq, eq, n, i, cyc, nMismatch, samplesChecked;
    cpx_exec i_cpx_exec (.*);
    cpx_cop_model u_cop (.*);
    initial forever #4 clk = ~clk;
    function automatic logic ct(input logic [3:0] k, input logic [4:0] x);
        logic [7:0] b;
        b = {x[3] == x[1] && !x[2], x[3] == x[1], !x[3], !x[1], !x[2], !x[0], !x[0] && !x[2], 1'b1};
        return b[k[3:1]] ^ k[0];
    endfunction
    task conclude;
        if (nMismatch == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samplesChecked++;
        if (g !== e) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task hs(input bit x);
        int k;
        k = 0;
        do @(negedge clk); while (!(x ? extReady : instrReady) && ++k < 50);
        @(posedge clk) if (x) extValid <= 1'b0; else instrValid <= 1'b0;
    endtask
    task putOp(input logic [15:0] w);
        @(posedge clk) {instrWord, instrAddr, instrValid} <= {w, a, 1'b1};
        hs(0);
    endtask
    task putExt(input logic [15:0] w);
        @(posedge clk) {extWord, extValid} <= {w, 1'b1};
        hs(1);
    endtask
    task fin(input logic [7:0] e, input logic [31:0] p);
        int k;
        k = 0;
        do @(negedge clk); while (!done && ++k < 60);
        @(posedge clk) #1;
        chk("events", e, gEv);
        chk("requests", eq, nReq);
        if (e[7] | e[6]) chk("pc", p, gPc);
        if (e[5]) chk("byte", eB, gByte);
        if (e[4]) chk("counter", eR, gReg);
        if (e[3]) chk("flags", cw[4:0], gCc);
    endtask
    always @(posedge clk) if (resetn) begin
        gEv <= (instrValid && instrReady ? 8'h00 : gEv) |
               {pcLoad, trapTake, byteWr, regWr, ccLoad, lineFTrap, mmuReq, illegalEa};
        if (pcLoad) gPc <= pcValue;
        if (trapTake) gPc <= trapPc;
        if (byteWr) gByte <= byteData;
        if (regWr) gReg <= regData;
        if (ccLoad) gCc <= ccValue;
        cyc++;
        if (cyc > 20000) begin
            nMismatch++;
            conclude;
        end
    end
    initial begin
        void'($urandom(32'hFEB4));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 240; i++) begin
            {id, cw, a} = {3'($urandom), 16'($urandom), $urandom & 32'hFFFF_FFFE};
            @(posedge clk) dly <= 4'($urandom % 5);
            ccIn <= 5'($urandom);
            dnRead <= (i % 5 == 0) ? {16'($urandom), 16'h0000} : $urandom;
            case (i % 4)
                0: begin
                    putOp({4'hF, id, 3'h0, cw[8:3]});
                    if (id == 3'h0) fin(8'h02, a);
                    else begin
                        eq++;
                        putExt(cw);
                        fin(cw[15] ? 8'h88 : 8'h80, a + 32'h4);
                        chk("command", {1'b0, id, cw}, {lastCond, lastId, lastWord});
                    end
                end
                1: begin
                    {m, r} = 6'($urandom);
                    if (id == 3'h0) m = 3'h0;
                    if (m == 3'h7 && r inside {[2:4]}) r = r + 3'h3;
                    putOp({4'hF, id, 3'h1, m, r});
                    if (id == 3'h0) fin(8'h04, a);
                    else if (m == 3'h1 || (m == 3'h7 && r > 3'h1)) fin(8'h01, a);
                    else begin
                        {eq, eB} = {eq + 1, cw[0] ? 8'hFF : 8'h00};
                        putExt(cw);
                        fin(8'hA0, a + 32'h4);
                        chk("condition", {1'b1, 10'h0, cw[5:0]}, {lastCond, lastWord});
                        chk("destination", {m, r}, {byteEaMode, byteEaReg});
                    end
                end
                2: begin
                    f = 3'h2 + 3'($urandom % 3);
                    n = (f == 3'h4) ? 0 : int'(f) - 1;
                    putOp({4'hF, id, 3'h1, 3'h7, f});
                    if (id == 3'h0) fin(8'h04, a);
                    else begin
                        eq++;
                        putExt(cw);
                        repeat (n) putExt(16'($urandom));
                        fin(cw[0] ? 8'h40 : 8'h80, a + 32'(4 + 2 * n));
                        chk("vector", 8'h07, trapVector);
                        chk("trap word", {1'b1, 10'h0, cw[5:0]}, {lastCond, lastWord});
                    end
                end
                default: begin
                    {c, r} = {4'(i / 4 % 16), 3'($urandom)};
                    putOp({4'h5, c, 5'h19, r});
                    putExt(cw);
                    eR = {dnRead[31:16], dnRead[15:0] - 16'h1};
                    eP = a + 32'h2 + {{16{cw[15]}}, cw};
                    if (eR[15:0] == 16'hFFFF) eP = a + 32'h4;
                    if (ct(c, ccIn)) fin(8'h80, a + 32'h4);
                    else fin(8'h90, eP);
                    chk("counter index", r, dnIndex);
                end
            endcase
        end
        conclude;
    end
endmodule

//--- cpx_cond_eval.sv
// Evaluator of the sixteen integer condition tests
`timescale 1ns/100ps
module cpx_cond_eval (
    input  wire logic [3:0] code,
    input  wire logic [4:0] flags,
    output logic            condTrue
);
    logic n;
    logic z;
    logic v;
    logic c;

    assign n = flags[cpx_pkg::FLAG_N];
    assign z = flags[cpx_pkg::FLAG_Z];
    assign v = flags[cpx_pkg::FLAG_V];
    assign c = flags[cpx_pkg::FLAG_C];

    always_comb begin
        unique case (code)
            cpx_pkg::CC_T:  condTrue = 1'b1;
            cpx_pkg::CC_F:  condTrue = 1'b0;
            cpx_pkg::CC_HI: condTrue = !c && !z;
            cpx_pkg::CC_LS: condTrue = c || z;
            cpx_pkg::CC_CC: condTrue = !c;
            cpx_pkg::CC_CS: condTrue = c;
            cpx_pkg::CC_NE: condTrue = !z;
            cpx_pkg::CC_EQ: condTrue = z;
            cpx_pkg::CC_VC: condTrue = !v;
            cpx_pkg::CC_VS: condTrue = v;
            cpx_pkg::CC_PL: condTrue = !n;
            cpx_pkg::CC_MI: condTrue = n;
            cpx_pkg::CC_GE: condTrue = n == v;
            cpx_pkg::CC_LT: condTrue = n != v;
            cpx_pkg::CC_GT: condTrue = !z && (n == v);
            cpx_pkg::CC_LE: condTrue = z || (n != v);
        endcase
    end
endmodule

//--- cpx_cop_model.sv
// Behavioural coprocessor answering command and condition words
`timescale 1ns/100ps
module cpx_cop_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  dly,
    input  wire logic        cpReqValid,
    input  wire logic [2:0]  cpReqId,
    input  wire logic [15:0] cpReqWord,
    input  wire logic        cpReqIsCond,
    output logic             cpRespValid,
    output logic             cpRespCondTrue,
    output logic             cpRespCcWrite,
    output logic [4:0]       cpRespCc,
    output logic [15:0]      lastWord,
    output logic [2:0]       lastId,
    output logic             lastCond,
    output int               nReq
);
    logic [3:0] cnt;
    logic       ans;
    always_ff @(posedge clk) begin
        cpRespValid    <= 1'b0;
        cpRespCondTrue <= ~cpRespCondTrue;
        cpRespCcWrite  <= ~cpRespCcWrite;
        cpRespCc       <= ~cpRespCc;
        if (!resetn) begin
            {cnt, ans, cpRespCondTrue, cpRespCcWrite, cpRespCc} <= '0;
            nReq <= 0;
        end else if (cpReqValid && !ans) begin
            cnt <= cnt + 4'h1;
            if (cnt >= dly) begin
                cpRespValid    <= 1'b1;
                cpRespCondTrue <= cpReqWord[0];
                cpRespCcWrite  <= !cpReqIsCond && cpReqWord[15];
                cpRespCc       <= cpReqWord[4:0];
                {ans, cnt}     <= {1'b1, 4'h0};
                {lastWord, lastId, lastCond} <= {cpReqWord, cpReqId, cpReqIsCond};
                nReq           <= nReq + 1;
            end
        end else if (!cpReqValid) begin
            ans <= 1'b0;
        end
    end
endmodule

//--- cpx_ea_check.sv
// Check for data alterable destination addressing modes
`timescale 1ns/100ps
module cpx_ea_check (
    input  wire logic [2:0] mode,
    input  wire logic [2:0] eaReg,
    output logic            dataAlterable
);
    always_comb begin
        if (mode == cpx_pkg::MODE_EXT) begin
            dataAlterable = (eaReg == cpx_pkg::REG_ABS_WORD) ||
                            (eaReg == cpx_pkg::REG_ABS_LONG);
        end else begin
            dataAlterable = mode != cpx_pkg::MODE_AREG;
        end
    end
endmodule

//--- cpx_exec.sv
// Execution of coprocessor general, set, trap and integer loop instructions
// What this block does
// - General op forwards the following command word to the identified coprocessor.
// - General op leaves condition codes alone unless the coprocessor changes them.
// - General op with identifier zero goes to memory-management handling.
// - Operand location legality for general op is left to the coprocessor.
// - Set op writes all ones if condition true, else zeros; flags kept.
// - Condition word follows op word, upper ten bits zero, passed on.
// - Set and trap ops with identifier zero raise unimplemented line-F.
// - Set op destination must be a data alterable mode.
// - Trap op with true condition starts exception through vector seven.
// - Stacked address for the trap is the following instruction.
// - Trap op with false condition continues with next instruction.
// - Trap form field selects one, two or no operand words.
// - Trap operand words are handler data and are skipped.
// - Loop op with true condition does nothing further.
// - Loop op with false condition decrements only counter low word.
// - Low word minus one falls through, otherwise branch by displacement.
// - Branch base is loop op word address plus two.
// - Loop condition picks one of sixteen integer tests; flags unchanged.
// - Loop op holds condition, counter register and a displacement word.
`timescale 1ns/100ps
module cpx_exec (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        instrValid,
    output logic             instrReady,
    input  wire logic [15:0] instrWord,
    input  wire logic [31:0] instrAddr,
    input  wire logic        extValid,
    output logic             extReady,
    input  wire logic [15:0] extWord,
    input  wire logic [4:0]  ccIn,
    output logic             ccLoad,
    output logic [4:0]       ccValue,
    output logic             cpReqValid,
    output logic [2:0]       cpReqId,
    output logic [15:0]      cpReqWord,
    output logic             cpReqIsCond,
    input  wire logic        cpRespValid,
    input  wire logic        cpRespCondTrue,
    input  wire logic        cpRespCcWrite,
    input  wire logic [4:0]  cpRespCc,
    output logic [2:0]       dnIndex,
    input  wire logic [31:0] dnRead,
    output logic             regWr,
    output logic [31:0]      regData,
    output logic             byteWr,
    output logic [7:0]       byteData,
    output logic [2:0]       byteEaMode,
    output logic [2:0]       byteEaReg,
    output logic             pcLoad,
    output logic [31:0]      pcValue,
    output logic             trapTake,
    output logic [7:0]       trapVector,
    output logic [31:0]      trapPc,
    output logic             lineFTrap,
    output logic             mmuReq,
    output logic             illegalEa,
    output logic             done
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {IDLE, FETCH_WORD, CP_WAIT, SKIP, DISP} cpx_phase_t;
    typedef enum logic [1:0] {K_GEN, K_SET, K_TRAP, K_LOOP} cpx_kind_t;

    typedef struct packed {
        cpx_phase_t  phase;
        cpx_kind_t   kind;
        logic [15:0] op;
        logic [31:0] opAddr;
        logic [31:0] pc;
        logic [1:0]  skip;
        logic        condTrue;
        logic        cpReqValid;
        logic [15:0] cpReqWord;
        logic        byteWr;
        logic [7:0]  byteData;
        logic        regWr;
        logic [31:0] regData;
        logic        pcLoad;
        logic [31:0] pcValue;
        logic        trapTake;
        logic [31:0] trapPc;
        logic        lineF;
        logic        mmuReq;
        logic        illegalEa;
        logic        ccLoad;
        logic [4:0]  ccValue;
        logic        done;
    } cpx_state_t;

    cpx_state_t st;
    cpx_state_t next_st;

    // ------------------------------------------------------------
    // Decode of the incoming operation word
    // ------------------------------------------------------------
    logic        isLineF;
    logic        isGen;
    logic        isTrap;
    logic        isSet;
    logic        isLoop;
    logic [2:0]  newId;
    logic        eaOk;
    logic        loopCond;
    logic [15:0] countNext;
    logic [1:0]  trapWords;
    logic        finishTrap;
    logic        trapCond;

    assign isLineF = instrWord[15:12] == cpx_pkg::LINE_F_NIBBLE;
    assign newId   = instrWord[cpx_pkg::ID_LSB +: 3];
    assign isGen   = isLineF && (instrWord[8:6] == cpx_pkg::TYPE_GENERAL);
    assign isTrap  = isLineF && (instrWord[8:6] == cpx_pkg::TYPE_COND) &&
                     (instrWord[5:3] == cpx_pkg::TRAP_EA_MODE) &&
                     ((instrWord[2:0] == cpx_pkg::TRAP_ONE_WORD) ||
                      (instrWord[2:0] == cpx_pkg::TRAP_TWO_WORD) ||
                      (instrWord[2:0] == cpx_pkg::TRAP_NO_WORD));
    assign isSet   = isLineF && (instrWord[8:6] == cpx_pkg::TYPE_COND) && !isTrap;
    assign isLoop  = (instrWord[15:12] == cpx_pkg::LOOP_NIBBLE) &&
                     (instrWord[7:3] == cpx_pkg::LOOP_SUBCODE);

    cpx_ea_check u_ea (
        .mode          (instrWord[5:3]),
        .eaReg         (instrWord[2:0]),
        .dataAlterable (eaOk)
    );

    cpx_cond_eval u_cond (
        .code     (instrWord[cpx_pkg::COND_LSB +: 4]),
        .flags    (ccIn),
        .condTrue (loopCond)
    );

    assign countNext = dnRead[15:0] - cpx_pkg::COUNT_STEP;

    always_comb begin
        unique case (st.op[2:0])
            cpx_pkg::TRAP_ONE_WORD: trapWords = 2'd1;
            cpx_pkg::TRAP_TWO_WORD: trapWords = 2'd2;
            default:                trapWords = 2'd0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.byteWr    = 1'b0;
        next_st.regWr     = 1'b0;
        next_st.pcLoad    = 1'b0;
        next_st.trapTake  = 1'b0;
        next_st.lineF     = 1'b0;
        next_st.mmuReq    = 1'b0;
        next_st.illegalEa = 1'b0;
        next_st.ccLoad    = 1'b0;
        next_st.done      = 1'b0;
        finishTrap        = 1'b0;
        trapCond          = st.condTrue;
        unique case (st.phase)
            IDLE: begin
                if (instrValid && (isGen || isSet || isTrap || isLoop)) begin
                    next_st.op     = instrWord;
                    next_st.opAddr = instrAddr;
                    next_st.pc     = instrAddr + cpx_pkg::WORD_BYTES;
                    next_st.phase  = FETCH_WORD;
                    if (isGen) begin
                        next_st.kind = K_GEN;
                        if (newId == cpx_pkg::MMU_ID) begin
                            next_st.mmuReq = 1'b1;
                            next_st.done   = 1'b1;
                            next_st.phase  = IDLE;
                        end
                    end else if (isLoop) begin
                        next_st.kind     = K_LOOP;
                        next_st.condTrue = loopCond;
                        next_st.phase    = DISP;
                    end else begin
                        next_st.kind = isTrap ? K_TRAP : K_SET;
                        if (newId == cpx_pkg::MMU_ID) begin
                            next_st.lineF = 1'b1;
                            next_st.done  = 1'b1;
                            next_st.phase = IDLE;
                        end else if (isSet && !eaOk) begin
                            next_st.illegalEa = 1'b1;
                            next_st.done      = 1'b1;
                            next_st.phase     = IDLE;
                        end
                    end
                end
            end
            FETCH_WORD: begin
                if (extValid) begin
                    next_st.pc         = st.pc + cpx_pkg::WORD_BYTES;
                    next_st.cpReqValid = 1'b1;
                    next_st.phase      = CP_WAIT;
                    if (st.kind == K_GEN) begin
                        next_st.cpReqWord = extWord;
                    end else begin
                        next_st.cpReqWord = {cpx_pkg::COND_ZEROS, extWord[5:0]};
                    end
                end
            end
            CP_WAIT: begin
                if (cpRespValid) begin
                    next_st.cpReqValid = 1'b0;
                    next_st.condTrue   = cpRespCondTrue;
                    unique case (st.kind)
                        K_GEN: begin
                            next_st.ccLoad  = cpRespCcWrite;
                            next_st.ccValue = cpRespCc;
                            next_st.pcLoad  = 1'b1;
                            next_st.pcValue = st.pc;
                            next_st.done    = 1'b1;
                            next_st.phase   = IDLE;
                        end
                        K_SET: begin
                            next_st.byteWr   = 1'b1;
                            next_st.byteData = cpRespCondTrue ? cpx_pkg::BYTE_TRUE
                                                              : cpx_pkg::BYTE_FALSE;
                            next_st.pcLoad   = 1'b1;
                            next_st.pcValue  = st.pc;
                            next_st.done     = 1'b1;
                            next_st.phase    = IDLE;
                        end
                        default: begin
                            trapCond     = cpRespCondTrue;
                            next_st.skip = trapWords;
                            if (trapWords == 2'd0) begin
                                finishTrap = 1'b1;
                            end else begin
                                next_st.phase = SKIP;
                            end
                        end
                    endcase
                end
            end
            SKIP: begin
                if (extValid) begin
                    next_st.pc   = st.pc + cpx_pkg::WORD_BYTES;
                    next_st.skip = st.skip - 2'd1;
                    if (st.skip == 2'd1) begin
                        finishTrap = 1'b1;
                    end
                end
            end
            DISP: begin
                if (extValid) begin
                    next_st.pcLoad = 1'b1;
                    next_st.done   = 1'b1;
                    next_st.phase  = IDLE;
                    next_st.pcValue = st.pc + cpx_pkg::WORD_BYTES;
                    if (!st.condTrue) begin
                        next_st.regWr   = 1'b1;
                        next_st.regData = {dnRead[31:16], countNext};
                        if (countNext != cpx_pkg::COUNT_END) begin
                            next_st.pcValue = st.pc + {{16{extWord[15]}}, extWord};
                        end
                    end
                end
            end
            default: begin
                next_st.phase = IDLE;
            end
        endcase
        if (finishTrap) begin
            next_st.done  = 1'b1;
            next_st.phase = IDLE;
            if (trapCond) begin
                next_st.trapTake = 1'b1;
                next_st.trapPc   = next_st.pc;
            end else begin
                next_st.pcLoad  = 1'b1;
                next_st.pcValue = next_st.pc;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign instrReady  = st.phase == IDLE;
    assign extReady    = (st.phase == FETCH_WORD) || (st.phase == SKIP) || (st.phase == DISP);
    assign cpReqValid  = st.cpReqValid;
    assign cpReqId     = st.op[cpx_pkg::ID_LSB +: 3];
    assign cpReqWord   = st.cpReqWord;
    assign cpReqIsCond = st.kind != K_GEN;
    assign dnIndex     = st.op[2:0];
    assign regWr       = st.regWr;
    assign regData     = st.regData;
    assign byteWr      = st.byteWr;
    assign byteData    = st.byteData;
    assign byteEaMode  = st.op[5:3];
    assign byteEaReg   = st.op[2:0];
    assign pcLoad      = st.pcLoad;
    assign pcValue     = st.pcValue;
    assign trapTake    = st.trapTake;
    assign trapVector  = cpx_pkg::TRAP_VECTOR;
    assign trapPc      = st.trapPc;
    assign lineFTrap   = st.lineF;
    assign mmuReq      = st.mmuReq;
    assign illegalEa   = st.illegalEa;
    assign ccLoad      = st.ccLoad;
    assign ccValue     = st.ccValue;
    assign done        = st.done;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_gen_forward_word: assert property (
        (st.phase == FETCH_WORD) && (st.kind == K_GEN) && extValid
        |=> cpReqValid && (cpReqWord == $past(extWord)) && !cpReqIsCond)
        else $error("command word not forwarded");
    a_cc_only_cop: assert property (
        ccLoad |-> $past(cpRespValid) && $past(cpRespCcWrite) && (ccValue == $past(cpRespCc)))
        else $error("condition codes changed without coprocessor");
    a_mmu_route_zero: assert property (
        instrReady && instrValid && isGen && (newId == cpx_pkg::MMU_ID)
        |=> mmuReq && done && !cpReqValid)
        else $error("identifier zero not routed to memory management");
    a_set_byte_value: assert property (
        byteWr |-> (byteData == ($past(cpRespCondTrue) ? 8'hFF : 8'h00)) && !ccLoad)
        else $error("set byte value wrong");
    a_cond_word_zeros: assert property (
        cpReqValid && cpReqIsCond |-> cpReqWord[15:6] == 10'h000)
        else $error("condition word upper bits not zero");
    a_linef_zero_id: assert property (
        instrReady && instrValid && (isSet || isTrap) && (newId == 3'h0)
        |=> lineFTrap ##1 !cpReqValid)
        else $error("line-F not raised for identifier zero");
    a_set_dest_mode: assert property (
        byteWr |-> (byteEaMode != 3'h1) &&
                   !((byteEaMode == 3'h7) && (byteEaReg > 3'h1)))
        else $error("set written to illegal destination");
    a_trap_stack_pc: assert property (
        trapTake |-> (trapVector == 8'h07) && (trapPc == st.opAddr +
                     (st.op[2] ? 32'h4 : {29'h0, st.op[1:0], 1'b0} + 32'h2)))
        else $error("trap address wrong");
    a_loop_upper_keep: assert property (
        regWr |-> (regData[31:16] == $past(dnRead[31:16])) &&
                  (regData[15:0] == $past(dnRead[15:0]) - 16'h1))
        else $error("loop counter update wrong");
    a_loop_fall_end: assert property (
        regWr && (regData[15:0] == 16'hFFFF) |-> pcLoad && (pcValue == st.opAddr + 32'h4))
        else $error("loop did not fall through at minus one");
    a_cop_stall: assert property (
        cpReqValid |-> !done && !byteWr && !trapTake && !pcLoad && !ccLoad)
        else $error("coprocessor instruction completed early");

    c_trap_taken: cover property (trapTake);
    c_set_true: cover property (byteWr && (byteData == 8'hFF));
    c_loop_branch: cover property (regWr && (regData[15:0] != 16'hFFFF));
    c_gen_cc: cover property (ccLoad);
endmodule

//--- cpx_pkg.sv
// Shared constants for the coprocessor and loop instruction execution logic
package cpx_pkg;

    // ------------------------------------------------------------
    // Operation word fields
    // ------------------------------------------------------------
    localparam logic [3:0]  LINE_F_NIBBLE = 4'hF;
    localparam logic [3:0]  LOOP_NIBBLE   = 4'h5;
    localparam logic [2:0]  TYPE_GENERAL  = 3'h0;
    localparam logic [2:0]  TYPE_COND     = 3'h1;
    localparam logic [4:0]  LOOP_SUBCODE  = 5'h19;
    localparam logic [2:0]  MMU_ID        = 3'h0;
    localparam int          ID_LSB        = 9;
    localparam int          TYPE_LSB      = 6;
    localparam int          MODE_LSB      = 3;
    localparam int          COND_LSB      = 8;

    // ------------------------------------------------------------
    // Trap forms and exception
    // ------------------------------------------------------------
    localparam logic [2:0]  TRAP_EA_MODE  = 3'h7;
    localparam logic [2:0]  TRAP_ONE_WORD = 3'h2;
    localparam logic [2:0]  TRAP_TWO_WORD = 3'h3;
    localparam logic [2:0]  TRAP_NO_WORD  = 3'h4;
    localparam logic [7:0]  TRAP_VECTOR   = 8'h07;

    // ------------------------------------------------------------
    // Effective address modes
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_DREG     = 3'h0;
    localparam logic [2:0]  MODE_AREG     = 3'h1;
    localparam logic [2:0]  MODE_EXT      = 3'h7;
    localparam logic [2:0]  REG_ABS_WORD  = 3'h0;
    localparam logic [2:0]  REG_ABS_LONG  = 3'h1;

    // ------------------------------------------------------------
    // Data values
    // ------------------------------------------------------------
    localparam logic [7:0]  BYTE_TRUE     = 8'hFF;
    localparam logic [7:0]  BYTE_FALSE    = 8'h00;
    localparam logic [15:0] COUNT_END     = 16'hFFFF;
    localparam logic [15:0] COUNT_STEP    = 16'h0001;
    localparam logic [31:0] WORD_BYTES    = 32'h0000_0002;
    localparam logic [9:0]  COND_ZEROS    = 10'h000;

    // ------------------------------------------------------------
    // Integer condition codes, flags packed as {X,N,Z,V,C}
    // ------------------------------------------------------------
    localparam logic [3:0]  CC_T  = 4'h0;
    localparam logic [3:0]  CC_F  = 4'h1;
    localparam logic [3:0]  CC_HI = 4'h2;
    localparam logic [3:0]  CC_LS = 4'h3;
    localparam logic [3:0]  CC_CC = 4'h4;
    localparam logic [3:0]  CC_CS = 4'h5;
    localparam logic [3:0]  CC_NE = 4'h6;
    localparam logic [3:0]  CC_EQ = 4'h7;
    localparam logic [3:0]  CC_VC = 4'h8;
    localparam logic [3:0]  CC_VS = 4'h9;
    localparam logic [3:0]  CC_PL = 4'hA;
    localparam logic [3:0]  CC_MI = 4'hB;
    localparam logic [3:0]  CC_GE = 4'hC;
    localparam logic [3:0]  CC_LT = 4'hD;
    localparam logic [3:0]  CC_GT = 4'hE;
    localparam logic [3:0]  CC_LE = 4'hF;
    localparam int          FLAG_N = 3;
    localparam int          FLAG_Z = 2;
    localparam int          FLAG_V = 1;
    localparam int          FLAG_C = 0;

endpackage
